// ---- inc/serial_params.svh ----
/*
  Offsets, field positions, reset values and timing floor of the serial port block.
  Assumes byte addressing on a 32-bit AXI4-Lite register bus.
*/
`ifndef SERIAL_PARAMS_SVH
`define SERIAL_PARAMS_SVH
`define A_CTRL   8'h00
`define A_BAUD   8'h04
`define A_TX     8'h08
`define A_RX     8'h0c
`define A_STAT   8'h10
`define A_PSEL   8'h14
`define C_W8     0
`define C_NINTH  1
`define C_CLKD   2
`define C_MST    3
`define C_SMD    4
`define C_GPO    6
`define C_GDIR   7
`define C_GOUT   8
`define C_HDLC   9
`define C_IRDA   10
`define S_BUSY   0
`define S_AVAIL  1
`define S_OVR    2
`define S_PROGRAMMING_CONNECTOR   3
`define S_GPIN   4
`define S_PERR   5
`define RX_VALID 31
`define MIN_DIV  16'h0008
`define BAUD_RST 16'h0008
`define CTRL_RST 11'h001
`define RESP_OK  2'h0
`define RESP_ERR 2'h2
`endif

// ---- inc/serial_pkg.sv ----
/*
  Types of the serial port block: engine states and the packed state record.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package serial_pkg;
  typedef enum logic {TX_IDLE, TX_RUN} tx_st_t;
  typedef enum logic {RX_IDLE, RX_RUN} rx_st_t;
  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [31:0] rdata;
    logic [10:0] ctrl;
    logic [15:0] baud;
    logic [3:0]  psel;
    logic [3:0]  sy1;
    logic [3:0]  sy2;
    logic [1:0]  sp;
    logic [1:0]  boot_cnt;
    logic        programming_connector;
    logic        boot_serial;
    logic        exec_zero;
    tx_st_t      tx_st;
    logic [11:0] tx_sh;
    logic [3:0]  tx_cnt;
    logic [15:0] tx_div;
    logic        txd;
    logic        sclk_o;
    logic        sclk_oe;
    rx_st_t      rx_st;
    logic [8:0]  rx_sh;
    logic [3:0]  rx_cnt;
    logic [15:0] rx_div;
    logic [8:0]  fq0;
    logic [8:0]  fq1;
    logic [1:0]  fcnt;
    logic        ovr;
    logic        status_n;
    logic        f_ok;
    logic        f_irda;
  } st_t;
endpackage : serial_pkg

// ---- src/serial_ports.sv ----
/*
  Serial port A engine (async or clocked), startup-mode capture, status pin,
  port F routing check, AXI4-Lite register slave.
  Assumes pins are asynchronous to aclk; first_fetch and int_ack come from aclk logic.
*/
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`include "serial_params.svh"

module serial_ports (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output      logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  input  wire logic        port_a_rxd,
  output      logic        port_a_txd,
  input  wire logic        port_a_serial_clock_i,
  output      logic        port_a_serial_clock_o,
  output      logic        port_a_serial_clock_oe,
  input  wire logic        startup_sel_0,
  input  wire logic        startup_sel_1,
  input  wire logic        first_fetch,
  input  wire logic        int_ack,
  output      logic        status_n,
  output      logic        program_mode,
  output      logic        boot_serial,
  output      logic        exec_zero,
  output      logic        port_f_clock_ok,
  output      logic        port_f_irda
);
  import serial_pkg::*;

  st_t         s_r;
  st_t         s_nxt;
  logic [3:0]  nb;
  logic [3:0]  tot;
  logic        en;
  logic        clk_md;
  logic        mst;
  logic        rise;
  logic        wr_go;
  logic        push;
  logic        pop;
  logic [15:0] dv;
  logic [31:0] w;
  logic [8:0]  rw;
  logic [8:0]  pv;
  logic [11:0] fr;

  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d,
                                      input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction : mrg

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt  = s_r;
    nb     = s_r.ctrl[`C_W8] ? 4'h8 : 4'h7;
    en     = s_r.ctrl[`C_NINTH];
    tot    = nb + {3'h0, en} + 4'h2;
    clk_md = s_r.ctrl[`C_CLKD] & ~s_r.programming_connector;
    mst    = s_r.ctrl[`C_MST];
    dv     = (s_r.baud < `MIN_DIV) ? `MIN_DIV : s_r.baud;
    rise   = s_r.sy2[1] & ~s_r.sp[1];
    wr_go  = 1'b0;
    push   = 1'b0;
    pop    = 1'b0;
    rw     = s_r.wdata[8:0];
    pv     = 9'h000;
    fr     = 12'hfff;
    w      = 32'h0000_0000;
    // Pin synchronisers
    s_nxt.sy1 = {startup_sel_1, startup_sel_0, port_a_serial_clock_i, port_a_rxd};
    s_nxt.sy2 = s_r.sy1;
    s_nxt.sp  = s_r.sy2[1:0];
    // Startup mode capture
    if (s_r.boot_cnt != 2'h3) begin
      s_nxt.boot_cnt = s_r.boot_cnt + 2'h1;
      if (s_r.boot_cnt == 2'h2) begin
        s_nxt.programming_connector        = s_r.sy2[3] & s_r.sy2[2];
        s_nxt.boot_serial = s_r.sy2[3] & s_r.sy2[2];
        s_nxt.exec_zero   = ~(s_r.sy2[3] & s_r.sy2[2]);
      end
    end
    // Register writes
    if (s_axi_awvalid & s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.aw_got & s_r.w_got & ~s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = `RESP_OK;
      case (s_r.awaddr)
        `A_CTRL: begin
          w = mrg({21'h0, s_r.ctrl}, s_r.wdata, s_r.wstrb);
          s_nxt.ctrl = w[10:0];
        end
        `A_BAUD: begin
          w = mrg({16'h0, s_r.baud}, s_r.wdata, s_r.wstrb);
          s_nxt.baud = w[15:0];
        end
        `A_TX: begin
          wr_go = (s_r.tx_st == TX_IDLE) & (~clk_md | ~mst | (s_r.fcnt != 2'h2));
        end
        `A_STAT: begin
          if (s_r.wdata[`S_OVR] & s_r.wstrb[0]) s_nxt.ovr = 1'b0;
        end
        `A_PSEL: begin
          if (s_r.wstrb[0]) s_nxt.psel = s_r.wdata[3:0];
        end
        `A_RX: begin
          s_nxt.bresp = `RESP_OK;
        end
        default: begin
          s_nxt.bresp = `RESP_ERR;
        end
      endcase
    end
    if (s_r.bvalid & s_axi_bready) s_nxt.bvalid = 1'b0;
    s_nxt.awready = ~s_nxt.aw_got & ~s_nxt.bvalid;
    s_nxt.wready  = ~s_nxt.w_got & ~s_nxt.bvalid;
    // Register reads
    if (s_axi_arvalid & s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = `RESP_OK;
      s_nxt.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        `A_CTRL: s_nxt.rdata = {21'h0, s_r.ctrl};
        `A_BAUD: s_nxt.rdata = {16'h0, s_r.baud};
        `A_TX:   s_nxt.rdata = 32'h0000_0000;
        `A_RX: begin
          s_nxt.rdata = {s_r.fcnt != 2'h0, 22'h0, s_r.fq0};
          pop = s_r.fcnt != 2'h0;
        end
        `A_STAT: begin
          s_nxt.rdata = {26'h0, s_r.psel[1:0] != s_r.psel[3:2], s_r.sy2[1], s_r.programming_connector,
                         s_r.ovr, s_r.fcnt != 2'h0, s_r.tx_st == TX_RUN};
        end
        `A_PSEL: s_nxt.rdata = {28'h0, s_r.psel};
        default: s_nxt.rresp = `RESP_ERR;
      endcase
    end
    if (s_r.rvalid & s_axi_rready) s_nxt.rvalid = 1'b0;
    s_nxt.arready = ~s_nxt.rvalid;
    // Transmit and clocked shift engine
    case (s_r.tx_st)
      TX_IDLE: begin
        if (wr_go) begin
          s_nxt.tx_st  = TX_RUN;
          s_nxt.tx_div = dv - 16'h0001;
          if (clk_md) begin
            s_nxt.txd    = rw[0];
            s_nxt.tx_sh  = {5'h1f, rw[7:1]};
            s_nxt.tx_cnt = 4'h8;
            if (mst) s_nxt.sclk_o = 1'b1;
          end else begin
            fr[0] = 1'b0;
            for (int i = 0; i < 8; i++) begin
              if (i < int'(nb)) fr[i+1] = rw[i];
            end
            if (en) fr[nb+4'h1] = rw[8];
            s_nxt.txd    = fr[0];
            s_nxt.tx_sh  = {1'b1, fr[11:1]};
            s_nxt.tx_cnt = tot;
          end
        end
      end
      TX_RUN: begin
        if (!clk_md) begin
          if (s_r.tx_div == 16'h0000) begin
            s_nxt.tx_div = dv - 16'h0001;
            if (s_r.tx_cnt == 4'h1) begin
              s_nxt.tx_st = TX_IDLE;
              s_nxt.txd   = 1'b1;
            end else begin
              s_nxt.txd    = s_r.tx_sh[0];
              s_nxt.tx_sh  = {1'b1, s_r.tx_sh[11:1]};
              s_nxt.tx_cnt = s_r.tx_cnt - 4'h1;
            end
          end else begin
            s_nxt.tx_div = s_r.tx_div - 16'h0001;
          end
        end else begin
          if (mst) begin
            rise = 1'b0;
            if (s_r.tx_div == 16'h0000) begin
              s_nxt.tx_div = dv - 16'h0001;
              s_nxt.sclk_o = ~s_r.sclk_o;
              rise         = ~s_r.sclk_o;
            end else begin
              s_nxt.tx_div = s_r.tx_div - 16'h0001;
            end
          end
          if (rise) begin
            s_nxt.rx_sh = {s_r.sy2[0], s_r.rx_sh[8:1]};
            if (s_r.tx_cnt == 4'h1) begin
              s_nxt.tx_st = TX_IDLE;
              push        = 1'b1;
              pv          = {1'b0, s_nxt.rx_sh[8:1]};
            end else begin
              s_nxt.txd    = s_r.tx_sh[0];
              s_nxt.tx_sh  = {1'b1, s_r.tx_sh[11:1]};
              s_nxt.tx_cnt = s_r.tx_cnt - 4'h1;
            end
          end
        end
      end
      default: s_nxt.tx_st = TX_IDLE;
    endcase
    // Async receiver
    case (s_r.rx_st)
      RX_IDLE: begin
        if (~clk_md & ~s_r.sy2[0] & s_r.sp[0]) begin
          s_nxt.rx_st  = RX_RUN;
          s_nxt.rx_div = {1'b0, dv[15:1]};
          s_nxt.rx_cnt = 4'h0;
        end
      end
      RX_RUN: begin
        if (clk_md) begin
          s_nxt.rx_st = RX_IDLE;
        end else if (s_r.rx_div == 16'h0000) begin
          s_nxt.rx_div = dv - 16'h0001;
          s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
          if (s_r.rx_cnt == 4'h0) begin
            if (s_r.sy2[0]) s_nxt.rx_st = RX_IDLE;
          end else if (s_r.rx_cnt == tot - 4'h1) begin
            s_nxt.rx_st = RX_IDLE;
            push        = s_r.sy2[0];
            pv          = s_r.rx_sh >> (4'h9 - nb - {3'h0, en});
          end else begin
            s_nxt.rx_sh = {s_r.sy2[0], s_r.rx_sh[8:1]};
          end
        end else begin
          s_nxt.rx_div = s_r.rx_div - 16'h0001;
        end
      end
      default: s_nxt.rx_st = RX_IDLE;
    endcase
    // Two-entry receive buffer
    if (pop) begin
      s_nxt.fq0  = s_r.fq1;
      s_nxt.fcnt = s_r.fcnt - 2'h1;
    end
    if (push) begin
      if (s_nxt.fcnt == 2'h2) begin
        s_nxt.ovr = 1'b1;
      end else begin
        if (s_nxt.fcnt == 2'h0) s_nxt.fq0 = pv;
        else s_nxt.fq1 = pv;
        s_nxt.fcnt = s_nxt.fcnt + 2'h1;
      end
    end
    // Clock pin ownership
    if (!clk_md) begin
      s_nxt.sclk_oe = s_r.ctrl[`C_GDIR];
      s_nxt.sclk_o  = s_r.ctrl[`C_GOUT];
    end else begin
      s_nxt.sclk_oe = mst;
      if (s_r.tx_st == TX_IDLE) s_nxt.sclk_o = 1'b1;
    end
    // Status pin
    case (s_r.ctrl[`C_SMD +: 2])
      2'h0:    s_nxt.status_n = ~first_fetch;
      2'h1:    s_nxt.status_n = ~int_ack;
      default: s_nxt.status_n = s_r.ctrl[`C_GPO];
    endcase
    s_nxt.f_ok   = s_r.ctrl[`C_HDLC] & (s_r.psel[1:0] == s_r.psel[3:2]);
    s_nxt.f_irda = s_r.ctrl[`C_HDLC] & s_r.ctrl[`C_IRDA];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r          <= '0;
      s_r.ctrl     <= `CTRL_RST;
      s_r.baud     <= `BAUD_RST;
      s_r.txd      <= 1'b1;
      s_r.sclk_o   <= 1'b1;
      s_r.status_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready          = s_r.awready;
  assign s_axi_wready           = s_r.wready;
  assign s_axi_bvalid           = s_r.bvalid;
  assign s_axi_bresp            = s_r.bresp;
  assign s_axi_arready          = s_r.arready;
  assign s_axi_rvalid           = s_r.rvalid;
  assign s_axi_rdata            = s_r.rdata;
  assign s_axi_rresp            = s_r.rresp;
  assign port_a_txd             = s_r.txd;
  assign port_a_serial_clock_o  = s_r.sclk_o;
  assign port_a_serial_clock_oe = s_r.sclk_oe;
  assign status_n               = s_r.status_n;
  assign program_mode           = s_r.programming_connector;
  assign boot_serial            = s_r.boot_serial;
  assign exec_zero              = s_r.exec_zero;
  assign port_f_clock_ok        = s_r.f_ok;
  assign port_f_irda            = s_r.f_irda;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bit_floor: assert property (
    ($rose(port_a_txd) && s_r.tx_st == TX_RUN && !clk_md) |-> ##1 $stable(port_a_txd)[*7])
    else $error("async bit shorter than eight clocks");
  a_start_low: assert property (
    (s_r.tx_st == TX_IDLE && wr_go && !clk_md) |=> !port_a_txd)
    else $error("async frame does not open with a low start bit");
  a_frame_len: assert property (
    (s_r.tx_st == TX_IDLE && wr_go && !clk_md) |=> s_r.tx_cnt == $past(tot))
    else $error("frame length does not match word size");
  a_ninth_pos: assert property (
    (s_r.tx_st == TX_IDLE && wr_go && !clk_md && en) |=> s_r.tx_sh[$past(nb)] == $past(rw[8]))
    else $error("ninth bit not placed after the data");
  a_slave_clk: assert property (
    (clk_md && !mst) |=> !port_a_serial_clock_oe)
    else $error("clock slave drives the clock line");
  a_gpio_pin: assert property (
    !clk_md |=> port_a_serial_clock_oe == $past(s_r.ctrl[`C_GDIR]))
    else $error("clock line not released to general I/O");
  a_programming_connector_async: assert property (
    (s_r.programming_connector && !s_r.ctrl[`C_GDIR]) |=> !port_a_serial_clock_oe)
    else $error("clocked mode active in program mode");
  a_boot_sel: assert property (
    (s_r.boot_cnt == 2'h2) |=> program_mode == ($past(s_r.sy2[3]) && $past(s_r.sy2[2])))
    else $error("startup pins not captured correctly");
  a_boot_excl: assert property (
    !(boot_serial && exec_zero))
    else $error("cold boot and run from zero both selected");
  a_status_ff: assert property (
    (s_r.ctrl[`C_SMD +: 2] == 2'h0 && first_fetch) |=> !status_n)
    else $error("status pin missed first fetch");
  a_fsel_chk: assert property (
    (s_r.psel[1:0] != s_r.psel[3:2]) |=> !port_f_clock_ok)
    else $error("port F clock allowed from another group");

  c_async_tx: cover property (s_r.tx_st == TX_RUN && !clk_md ##1 s_r.tx_st == TX_IDLE);
  c_clk_mst:  cover property (clk_md && mst && push);
  c_fifo_ful: cover property (s_r.fcnt == 2'h2);
  c_programming_connector:     cover property (s_r.boot_cnt == 2'h3 && program_mode);
endmodule : serial_ports

// ---- test/serial_peer.sv ----
/*
  Far-side serial peer of port A: async characters both ways, clocked bits on the clock line.
  Assumes the bench resolves the clock wire from both drivers and calls these tasks.
*/
`timescale 1ns/1ns
module serial_peer (
  input  wire logic txd,
  input  wire logic sclk_wire,
  output      logic rxd,
  output      logic clk
);
  localparam int BIT_NS = 32;
  logic       clk_mode;
  logic [7:0] out_b;
  logic [7:0] in_b;
  int         k;

  initial begin
    rxd = 1'b1;
    clk = 1'b1;
    clk_mode = 1'b0;
    k = 0;
    out_b = 8'h00;
    in_b = 8'h00;
  end

  //////////////////////////////////////////////////
  // Async character out, low start, lsb first, high stop
  task automatic send_async(input logic [8:0] v, input int n);
    rxd = 1'b0;
    #BIT_NS;
    for (int i = 0; i < n; i++) begin
      rxd = v[i];
      #BIT_NS;
    end
    rxd = 1'b1;
    #BIT_NS;
  endtask : send_async

  // Samples mid-bit, stop bit lands at position n
  task automatic recv_async(output logic [9:0] v, input int n);
    v = '0;
    @(negedge txd);
    #(BIT_NS / 2);
    for (int i = 0; i <= n; i++) begin
      #BIT_NS;
      v[i] = txd;
    end
  endtask : recv_async

  //////////////////////////////////////////////////
  task automatic start_clocked(input logic [7:0] b);
    out_b = b;
    k = 0;
    clk_mode = 1'b1;
  endtask : start_clocked

  // Peer as clock source, stands high outside frames
  task automatic clock_frame();
    repeat (8) begin
      #BIT_NS clk = 1'b0;
      #BIT_NS clk = 1'b1;
    end
  endtask : clock_frame

  // Low half: take txd, offer next bit
  always @(negedge sclk_wire) begin
    if (clk_mode && k < 8) begin
      in_b = {txd, in_b[7:1]};
      rxd = out_b[k];
      k = k + 1;
    end
  end

  // Released data line shows the inverse of its last bit
  always @(posedge sclk_wire) begin
    if (clk_mode && k == 8) begin
      k = 9;
      #BIT_NS rxd = ~rxd;
    end
  end
endmodule : serial_peer

// ---- test/multi_mode_serial_ports_boot_tb.sv ----
/*
  Self-checking bench of serial_ports: AXI4-Lite master tasks, queue model, serial peer.
  Assumes serial_peer on the port A pins and the map in serial_params.svh.
*/
`timescale 1ns/1ns
`include "serial_params.svh"
module multi_mode_serial_ports_boot_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, w, raw, exp, seed;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        txd, rxd, pclk, sclk_o, sclk_oe, sel, ffetch, iack;
  logic        status_n, program_mode, boot_serial, exec_zero, f_ok, f_irda;
  logic [9:0]  got;
  wire logic   sclk_wire;
  int          error_cnt, n_tests, nd, n;
  logic [31:0] rxq[$];

  assign sclk_wire = sclk_oe ? sclk_o : pclk;

  serial_ports i_serial_ports (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .port_a_rxd(rxd), .port_a_txd(txd), .port_a_serial_clock_i(sclk_wire),
    .port_a_serial_clock_o(sclk_o), .port_a_serial_clock_oe(sclk_oe),
    .startup_sel_0(sel), .startup_sel_1(sel), .first_fetch(ffetch), .int_ack(iack),
    .status_n(status_n), .program_mode(program_mode), .boot_serial(boot_serial),
    .exec_zero(exec_zero), .port_f_clock_ok(f_ok), .port_f_irda(f_irda)
  );

  serial_peer i_serial_peer (.txd(txd), .sclk_wire(sclk_wire), .rxd(rxd), .clk(pclk));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  //////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    n_tests++;
    if (seen !== expv) begin
      error_cnt++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, expv);
    end
  endtask : chk

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= v;
    wstrb   <= 4'hf;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axr

  task automatic rst(input logic p);
    @(posedge aclk);
    aresetn <= 1'b0;
    sel     <= p;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({program_mode, boot_serial, exec_zero}, {p, p, ~p});
  endtask : rst

  //////////////////////////////////////////////////
  initial begin
    seed = 32'd93886;
    error_cnt = 0;
    n_tests = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ffetch, iack} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    sel = 1'b1;
    rst(1'b1);
    axr(`A_CTRL, d, r);
    chk(d, 32'h001);
    axr(`A_STAT, d, r);
    chk(d[3], 1'b1);
    axw(8'h18, xs(), r);
    chk(r, `RESP_ERR);
    axr(8'h18, d, r);
    chk(d, 32'h0);
    chk(r, `RESP_ERR);
    axw(`A_BAUD, 32'h3, r);
    for (int m = 0; m < 4; m++) begin
      nd = m[0] ? 8 : 7;
      n = nd + m[1];
      axw(`A_CTRL, 32'h004 | m, r);
      w = xs();
      exp = (w & ((32'h1 << nd) - 32'h1)) | (32'h1 << n);
      exp = exp | (m[1] ? {31'h0, w[8]} << nd : 32'h0);
      fork
        i_serial_peer.recv_async(got, n);
        axw(`A_TX, {23'h0, w[8:0]}, r);
      join
      chk(got, exp);
      do axr(`A_STAT, d, r); while (d[0]);
      raw = xs() & ((32'h1 << n) - 32'h1);
      i_serial_peer.send_async(raw[8:0], n);
      rxq.push_back(32'h8000_0000 | raw);
      axr(`A_RX, d, r);
      chk(d, rxq.pop_front());
      $display("async format %0d done", m);
    end
    repeat (3) begin
      raw = xs() & 32'h1ff;
      i_serial_peer.send_async(raw[8:0], 9);
      if (rxq.size() < 2) rxq.push_back(32'h8000_0000 | raw);
    end
    axr(`A_STAT, d, r);
    chk(d[2:1], 2'b11);
    while (rxq.size() > 0) begin
      axr(`A_RX, d, r);
      chk(d, rxq.pop_front());
    end
    axr(`A_RX, d, r);
    chk(d[31], 1'b0);
    axw(`A_STAT, 32'h4, r);
    axr(`A_STAT, d, r);
    chk(d[2], 1'b0);
    $display("receive buffer done");
    rst(1'b0);
    for (int m = 0; m < 2; m++) begin
      axw(`A_CTRL, 32'h005 | (m << 3), r);
      w = xs();
      i_serial_peer.start_clocked(w[15:8]);
      axw(`A_TX, {24'h0, w[7:0]}, r);
      chk(sclk_oe, m);
      if (m == 0) i_serial_peer.clock_frame();
      else repeat (160) @(posedge aclk);
      repeat (12) @(posedge aclk);
      i_serial_peer.clk_mode = 1'b0;
      chk(i_serial_peer.in_b, w[7:0]);
      rxq.push_back(32'h8000_0000 | w[15:8]);
      axr(`A_RX, d, r);
      chk(d, rxq.pop_front());
      $display("clocked role %0d done", m);
    end
    for (int v = 0; v < 2; v++) begin
      axw(`A_CTRL, 32'h081 | (v << 8), r);
      repeat (2) @(posedge aclk);
      chk({sclk_oe, sclk_o}, {1'b1, v[0]});
    end
    axw(`A_CTRL, 32'h001, r);
    for (int v = 0; v < 2; v++) begin
      i_serial_peer.clk = v[0];
      repeat (4) @(posedge aclk);
      axr(`A_STAT, d, r);
      chk(d[4], v[0]);
    end
    for (int s = 0; s < 4; s++) begin
      axw(`A_CTRL, 32'h041 | (s << 4), r);
      ffetch <= 1'b1;
      @(posedge aclk);
      ffetch <= 1'b0;
      @(negedge aclk);
      chk(status_n, s != 0);
      @(posedge aclk);
      iack <= 1'b1;
      @(posedge aclk);
      iack <= 1'b0;
      @(negedge aclk);
      chk(status_n, s != 1);
      @(posedge aclk);
    end
    axw(`A_CTRL, 32'h021, r);
    repeat (2) @(posedge aclk);
    chk(status_n, 1'b0);
    $display("gpio and status done");
    for (int f = 0; f < 6; f++) begin
      w = xs();
      if (f > 3) w[3:2] = w[1:0];
      axw(`A_PSEL, {28'h0, w[3:0]}, r);
      axw(`A_CTRL, 32'h001 | (f[1:0] << 9), r);
      repeat (2) @(posedge aclk);
      chk({f_irda, f_ok}, {f[0] & f[1], f[0] && w[3:2] == w[1:0]});
      axr(`A_STAT, d, r);
      chk(d[5], w[3:2] != w[1:0]);
    end
    $display("port f checks done");
    end_of_test();
  end

  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
endmodule : multi_mode_serial_ports_boot_tb
